/* design/rlbfs_pkg.sv */
// Constants for the receive length-bin and checksum statistics block
package rlbfs_pkg;

    // ==========================================================
    // Widths
    localparam int LEN_W = 16;
    localparam int MAXLEN_W = 15;
    localparam int FCS_W = 32;
    localparam int BIN_N = 5;

    // ==========================================================
    // Length bin bounds in bytes, inclusive (bins A to E)
    localparam logic [LEN_W-1:0] BIN_LO [BIN_N] = '{16'h05F3, 16'h060D, 16'h0800, 16'h1000, 16'h2000};
    localparam logic [LEN_W-1:0] BIN_HI [BIN_N] = '{16'h060C, 16'h07FF, 16'h0FFF, 16'h1FFF, 16'h23FF};

    // Shortest frame counted by the in-range checksum error increment
    localparam logic [LEN_W-1:0] MIN_LEN = 16'h0040;

    // ==========================================================
    // Values after reset, and the one-event increment
    localparam logic [BIN_N-1:0] BIN_RST = 5'h00;
    localparam logic [1:0] CNT2_RST = 2'h0;
    localparam logic RANGE_RST = 1'h0;
    localparam logic [1:0] ONE_EVENT = 2'h1;

endpackage

/* design/rlbfs_stats.sv */
// Receive statistics increments: upper length bins and checksum error classes
`timescale 1ns/100ps

module rlbfs_stats
    import rlbfs_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Frame end report from the receive datapath
    input wire logic i_frame_end,
    input wire logic [LEN_W-1:0] i_frame_len,
    input wire logic [FCS_W-1:0] i_fcs_rx,
    input wire logic [FCS_W-1:0] i_fcs_calc,
    // Configuration
    input wire logic [MAXLEN_W-1:0] i_max_len,
    // Statistics increments
    output logic [BIN_N-1:0] o_len_bin_inc,
    output logic [1:0] o_bad_fcs_inc,
    output logic [1:0] o_stomped_fcs_inc,
    output logic o_range_bad_fcs_inc
);

    // ==========================================================
    // Frame classification
    logic [BIN_N-1:0] bin_hit;
    logic fcs_wrong;
    logic fcs_stomped;
    logic over_len;
    logic in_range;

    // The length already counts address through checksum bytes
    genvar g;
    generate
        for (g = 0; g < BIN_N; g++)
        begin : g_bin
            // One bin per range; bounds are inclusive
            assign bin_hit[g] = (i_frame_len >= BIN_LO[g]) && (i_frame_len <= BIN_HI[g]);
        end
    endgenerate

    // Stomped is an exact inversion of the expected value
    assign fcs_wrong = (i_fcs_rx != i_fcs_calc);
    assign fcs_stomped = (i_fcs_rx == ~i_fcs_calc);
    // Lengths past the configured 15-bit i_max_len are over-length
    assign over_len = (i_frame_len > {1'b0, i_max_len});
    assign in_range = (i_frame_len >= MIN_LEN) && !over_len;

    // ==========================================================
    // Next increment values
    logic [BIN_N-1:0] len_bin_d, len_bin_q;
    logic [1:0] bad_fcs_d, bad_fcs_q;
    logic [1:0] stomped_d, stomped_q;
    logic range_bad_d, range_bad_q;

    // Increments only live in the cycle after a frame end, so pulses may repeat each cycle
    always_comb
    begin
        len_bin_d = BIN_RST;
        bad_fcs_d = CNT2_RST;
        stomped_d = CNT2_RST;
        range_bad_d = RANGE_RST;
        if (i_frame_end)
        begin
            len_bin_d = bin_hit;
            if (fcs_wrong && !fcs_stomped)
            begin
                bad_fcs_d = ONE_EVENT;
            end
            if (fcs_stomped)
            begin
                stomped_d = ONE_EVENT;
            end
            range_bad_d = fcs_wrong && in_range;
        end
    end

    // Register the increments; outputs come straight from these
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            len_bin_q <= BIN_RST;
            bad_fcs_q <= CNT2_RST;
            stomped_q <= CNT2_RST;
            range_bad_q <= RANGE_RST;
        end
        else
        begin
            len_bin_q <= len_bin_d;
            bad_fcs_q <= bad_fcs_d;
            stomped_q <= stomped_d;
            range_bad_q <= range_bad_d;
        end
    end

    assign o_len_bin_inc = len_bin_q;
    assign o_bad_fcs_inc = bad_fcs_q;
    assign o_stomped_fcs_inc = stomped_q;
    assign o_range_bad_fcs_inc = range_bad_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);

    property p_bin_a;
        i_frame_end && i_frame_len >= 16'h05F3 && i_frame_len <= 16'h060C |=> o_len_bin_inc == 5'h01;
    endproperty
    a_bin_a: assert property (p_bin_a) else $error("bin A not pulsed alone");

    property p_bin_b;
        o_len_bin_inc[1] |-> $past(i_frame_end) && $past(i_frame_len) >= 16'h060D && $past(i_frame_len) <= 16'h07FF;
    endproperty
    a_bin_b: assert property (p_bin_b) else $error("bin B pulse without matching frame");

    property p_bin_c;
        i_frame_end && i_frame_len inside {[16'h0800:16'h0FFF]} |=> o_len_bin_inc[2] ##1 !o_len_bin_inc[2] || $past(i_frame_end);
    endproperty
    a_bin_c: assert property (p_bin_c) else $error("bin C pulse wrong");

    property p_bin_d;
        $rose(o_len_bin_inc[3]) |-> $past(i_frame_len) inside {[16'h1000:16'h1FFF]};
    endproperty
    a_bin_d: assert property (p_bin_d) else $error("bin D pulse for wrong length");

    property p_bin_e;
        i_frame_end && (i_frame_len == 16'h2000 || i_frame_len == 16'h23FF) |=> o_len_bin_inc[4];
    endproperty
    a_bin_e: assert property (p_bin_e) else $error("bin E missed its bounds");

    // Every bin fires alone anywhere inside its range
    property p_bin_b_only;
        i_frame_end && i_frame_len inside {[16'h060D:16'h07FF]} |=> o_len_bin_inc == 5'h02;
    endproperty
    a_bin_b_only: assert property (p_bin_b_only) else $error("bin B not pulsed alone");

    property p_bin_c_only;
        i_frame_end && i_frame_len inside {[16'h0800:16'h0FFF]} |=> o_len_bin_inc == 5'h04;
    endproperty
    a_bin_c_only: assert property (p_bin_c_only) else $error("bin C not pulsed alone");

    property p_bin_d_only;
        i_frame_end && i_frame_len inside {[16'h1000:16'h1FFF]} |=> o_len_bin_inc == 5'h08;
    endproperty
    a_bin_d_only: assert property (p_bin_d_only) else $error("bin D not pulsed alone");

    property p_bin_e_only;
        i_frame_end && i_frame_len inside {[16'h2000:16'h23FF]} |=> o_len_bin_inc == 5'h10;
    endproperty
    a_bin_e_only: assert property (p_bin_e_only) else $error("bin E not pulsed alone");

    // Lengths outside all upper bins raise no bin at all
    property p_below_bins;
        i_frame_end && i_frame_len < 16'h05F3 |=> o_len_bin_inc == 5'h00;
    endproperty
    a_below_bins: assert property (p_below_bins) else $error("bin pulsed for short frame");

    property p_above_bins;
        i_frame_end && i_frame_len > 16'h23FF |=> o_len_bin_inc == 5'h00;
    endproperty
    a_above_bins: assert property (p_above_bins) else $error("bin pulsed for long frame");

    // Without a frame end no bin or range pulse follows
    property p_bin_idle;
        !i_frame_end |=> o_len_bin_inc == 5'h00 && !o_range_bad_fcs_inc;
    endproperty
    a_bin_idle: assert property (p_bin_idle) else $error("length pulse without frame");

    property p_bad_fcs;
        i_frame_end && i_fcs_rx != i_fcs_calc && i_fcs_rx != ~i_fcs_calc |=> o_bad_fcs_inc == 2'h1 && o_stomped_fcs_inc == 2'h0;
    endproperty
    a_bad_fcs: assert property (p_bad_fcs) else $error("bad checksum not counted");

    property p_stomp_class;
        i_frame_end && i_fcs_rx == ~i_fcs_calc |=> o_stomped_fcs_inc == 2'h1 && o_bad_fcs_inc == 2'h0;
    endproperty
    a_stomp_class: assert property (p_stomp_class) else $error("stomped checksum misclassified");

    property p_bad_pulse;
        o_bad_fcs_inc != 2'h0 |-> $past(i_frame_end) ##1 (o_bad_fcs_inc == 2'h0 || $past(i_frame_end));
    endproperty
    a_bad_pulse: assert property (p_bad_pulse) else $error("bad checksum pulse stretched");

    property p_stomp_pulse;
        !i_frame_end |=> o_stomped_fcs_inc == 2'h0 && o_bad_fcs_inc == 2'h0;
    endproperty
    a_stomp_pulse: assert property (p_stomp_pulse) else $error("checksum pulse without frame");

    // A matching checksum is never reported as an error of any kind
    property p_good_fcs;
        i_frame_end && i_fcs_rx == i_fcs_calc
            |=> o_bad_fcs_inc == 2'h0 && o_stomped_fcs_inc == 2'h0 && !o_range_bad_fcs_inc;
    endproperty
    a_good_fcs: assert property (p_good_fcs) else $error("good checksum counted as error");

    // Bad checksums in consecutive cycles give pulses in consecutive cycles
    property p_bad_back;
        i_frame_end && i_fcs_rx != i_fcs_calc && i_fcs_rx != ~i_fcs_calc
            ##1 i_frame_end && i_fcs_rx != i_fcs_calc && i_fcs_rx != ~i_fcs_calc
            |-> o_bad_fcs_inc == 2'h1 ##1 o_bad_fcs_inc == 2'h1;
    endproperty
    a_bad_back: assert property (p_bad_back) else $error("back-to-back bad checksum lost");

    property p_stomp_back;
        i_frame_end && i_fcs_rx == ~i_fcs_calc ##1 i_frame_end && i_fcs_rx == ~i_fcs_calc
            |-> o_stomped_fcs_inc == 2'h1 ##1 o_stomped_fcs_inc == 2'h1;
    endproperty
    a_stomp_back: assert property (p_stomp_back) else $error("back-to-back stomped checksum lost");

    property p_range;
        i_frame_end && i_fcs_rx != i_fcs_calc && i_frame_len >= 16'h0040 && i_frame_len <= {1'b0, i_max_len}
            |=> o_range_bad_fcs_inc;
    endproperty
    a_range: assert property (p_range) else $error("in-range checksum error missed");

    property p_over_len;
        i_frame_end && (i_frame_len > {1'b0, i_max_len} || i_frame_len < 16'h0040) |=> !o_range_bad_fcs_inc;
    endproperty
    a_over_len: assert property (p_over_len) else $error("out-of-range frame counted");

endmodule

/* verif/rlbfs_count_model.sv */
// Counter model that totals the checksum increments
`timescale 1ns/100ps
module rlbfs_count_model
    import rlbfs_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Increments
    input wire logic [1:0] i_bad_inc,
    input wire logic [1:0] i_stomp_inc,
    // Totals
    output int o_bad_total,
    output int o_stomp_total
);
    // Add each increment every cycle; a lost pulse shows in the totals
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_bad_total <= 0;
            o_stomp_total <= 0;
        end
        else
        begin
            o_bad_total <= o_bad_total + int'(i_bad_inc);
            o_stomp_total <= o_stomp_total + int'(i_stomp_inc);
        end
    end
endmodule

/* verif/rlbfs_stats_tb.sv */
// Self-checking bench for the statistics increments
`timescale 1ns/100ps
module rlbfs_stats_tb;
    import rlbfs_pkg::*;
    // ==========================================
    // Stimulus and observed signals
    logic i_core_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_frame_end = 1'b0;
    logic [LEN_W-1:0] i_frame_len = 16'h0000;
    logic [FCS_W-1:0] i_fcs_rx = 32'h0;
    logic [FCS_W-1:0] i_fcs_calc = 32'h0;
    logic [MAXLEN_W-1:0] i_max_len = 15'h2580;
    logic [BIN_N-1:0] o_len_bin_inc;
    logic [1:0] o_bad_fcs_inc;
    logic [1:0] o_stomped_fcs_inc;
    logic o_range_bad_fcs_inc;
    int bad_total, stomp_total, num_errors = 0, cmp_count = 0, cycles = 0;
    always #12.5 i_core_clk = ~i_core_clk;
    rlbfs_stats u_dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_frame_end(i_frame_end),
        .i_frame_len(i_frame_len), .i_fcs_rx(i_fcs_rx), .i_fcs_calc(i_fcs_calc), .i_max_len(i_max_len),
        .o_len_bin_inc(o_len_bin_inc), .o_bad_fcs_inc(o_bad_fcs_inc),
        .o_stomped_fcs_inc(o_stomped_fcs_inc), .o_range_bad_fcs_inc(o_range_bad_fcs_inc));
    rlbfs_count_model u_model (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_bad_inc(o_bad_fcs_inc),
        .i_stomp_inc(o_stomped_fcs_inc), .o_bad_total(bad_total), .o_stomp_total(stomp_total));
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One frame end, then its increments, then all quiet again
    task automatic frame(input logic [LEN_W-1:0] len, input logic [FCS_W-1:0] rx, input logic [FCS_W-1:0] calc);
        logic [BIN_N-1:0] bin;
        logic err;
        logic stmp;
        for (int k = 0; k < BIN_N; k++)
            bin[k] = (len >= BIN_LO[k]) && (len <= BIN_HI[k]);
        err = (rx != calc);
        stmp = (rx == ~calc);
        @(posedge i_core_clk);
        i_frame_end <= 1'b1;
        i_frame_len <= len;
        i_fcs_rx <= rx;
        i_fcs_calc <= calc;
        @(posedge i_core_clk);
        i_frame_end <= 1'b0;
        #1;
        check(o_len_bin_inc, bin);
        check(o_bad_fcs_inc, {1'b0, err && !stmp});
        check(o_stomped_fcs_inc, {1'b0, stmp});
        check(o_range_bad_fcs_inc, err && len >= MIN_LEN && len <= i_max_len);
        @(posedge i_core_clk);
        #1;
        check({o_len_bin_inc, o_bad_fcs_inc, o_stomped_fcs_inc, o_range_bad_fcs_inc}, 0);
    endtask
    // Bin edges, good and bad checksums mixed
    task automatic t_bins;
        logic [LEN_W-1:0] lens [12] = '{16'h05F2, 16'h05F3, 16'h060C, 16'h060D, 16'h07FF, 16'h0800,
            16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000, 16'h23FF, 16'h2400};
        for (int k = 0; k < 12; k++)
            frame(lens[k], 32'hA5A50000 | k, 32'hA5A50000);
    endtask
    // Stomped, then a bad one just one bit short of stomped
    task automatic t_fcs;
        frame(16'h0640, 32'h0F0FF0F0, 32'hF0F00F0F);
        frame(16'h0640, 32'h0F0FF0F1, 32'hF0F00F0F);
    endtask
    // Range limits with a small and a full-width maximum
    task automatic t_range;
        i_max_len <= 15'h0640;
        frame(16'h003F, 32'h1, 32'h2);
        frame(16'h0040, 32'h1, 32'h2);
        frame(16'h0640, 32'h1, 32'h2);
        frame(16'h0641, 32'h1, 32'h2);
        i_max_len <= 15'h7FFF;
        frame(16'h7FFF, 32'h1, 32'h2);
    endtask
    // Frame ends every cycle, two bad then two stomped; totals must see each pulse
    task automatic t_back;
        int b0;
        int s0;
        b0 = bad_total;
        s0 = stomp_total;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge i_core_clk);
            i_frame_end <= 1'b1;
            i_fcs_calc <= 32'h0000FFFF;
            i_fcs_rx <= k[1] ? 32'hFFFF0000 : 32'h0000FFFE;
        end
        @(posedge i_core_clk);
        i_frame_end <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1;
        check(bad_total - b0, 2);
        check(stomp_total - s0, 2);
    endtask
    // Reset right after the edge that loads a pulse clears it; a frame right after release still counts
    task automatic t_reset;
        @(posedge i_core_clk);
        i_frame_end <= 1'b1;
        i_frame_len <= 16'h0640;
        i_fcs_rx <= 32'h1;
        i_fcs_calc <= 32'h2;
        @(posedge i_core_clk);
        i_frame_end <= 1'b0;
        i_reset_n <= 1'b0;
        #1;
        check({o_len_bin_inc, o_bad_fcs_inc, o_stomped_fcs_inc, o_range_bad_fcs_inc}, 0);
        @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        frame(16'h2000, 32'h1, 32'h2);
    endtask
    // Report and stop
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            results();
        end
    end
    // Main sequence
    initial
    begin
        repeat (16) @(posedge i_core_clk);
        check({o_len_bin_inc, o_bad_fcs_inc, o_stomped_fcs_inc, o_range_bad_fcs_inc}, 0);
        i_reset_n <= 1'b1;
        t_bins();
        t_fcs();
        t_range();
        t_back();
        t_reset();
        results();
    end
endmodule
